// [src/sif_pkg.sv]
// Constants, layouts and state types of the serial interface control block.
package sif_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CTRL = 8'hC3;
    localparam logic [7:0] IDX_STAT = 8'hC4;
    localparam logic [7:0] IDX_DATA = 8'hC5;
    localparam int         ADDR_MIN = 10;

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields and reset value.
    localparam int         CB_RATE2 = 7;
    localparam int         CB_EN    = 6;
    localparam int         CB_SELECT_DISABLE = 5;
    localparam int         CB_MASTER_SELECT  = 4;
    localparam int         CB_CLOCK_POLARITY  = 3;
    localparam int         CB_CLOCK_PHASE  = 2;
    localparam int         CB_RATE1 = 1;
    localparam int         CB_RATE0 = 0;
    localparam logic [7:0] CTRL_RST = 8'h14;

    ////////////////////////////////////////////////////////////////////////////
    // Status register fields; the low nibble reads as zero.
    localparam int         SB_TRANSFER_COMPLETE_FLAG  = 7;
    localparam int         SB_WRITE_COLLISION_FLAG  = 6;
    localparam int         SB_SLAVE_SELECT_ERROR_FLAG = 5;
    localparam int         SB_MODE_FAULT_FLAG  = 4;
    localparam logic [3:0] STAT_RSV = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Transfer and bus constants.
    localparam logic [2:0] RATE_BAD  = 3'h7;
    localparam logic [3:0] EDGE_LAST = 4'hF;
    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [1:0] HT_NONSEQ = 2'h2;
    localparam logic       HR_OKAY   = 1'h0;

    typedef enum logic [1:0] {SEL_NONE, SEL_CTRL, SEL_STAT, SEL_DATA} sif_sel_t;
    typedef enum logic {PH_IDLE, PH_XFER} sif_phase_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic       transfer_complete_flag;
        logic       write_collision_flag;
        logic       slave_select_error_flag;
        logic       mode_fault_flag;
        logic       spifArm;
        logic       wcolArm;
        logic       modfArm;
        logic [7:0] rxBuf;
        logic [7:0] txSh;
        logic [7:0] rxSh;
        logic       outBit;
        sif_phase_t phase;
        logic [3:0] bitCnt;
        logic [6:0] divCnt;
        logic       sckOut;
        logic       sckPrev;
        logic       ssPrev;
        logic       sckOen;
        logic       mosiOen;
        logic       misoOen;
        logic       wrPend;
        sif_sel_t   apSel;
        logic [7:0] rdData;
        logic       rdy;
        logic       resp;
        logic       txReq;
        logic       rxReq;
        logic       irq;
    } sif_state_t;

endpackage

// [src/sif_spi_ctrl.sv]
// Serial interface control, status and shift engine behind an AHB-Lite slave.
//
// Functional notes
// - Master, select honoured, select low sets fault.
// - Fault clears enable and master bits.
// - Fault requests interrupt only with select honoured.
// - Status read then control write clears fault.
// - Data write while busy flags collision.
// - Status then data access clears collision.
// - Unread byte kept, later bytes dropped silently.
// - Slave select rising mid-byte sets error.
// - Byte done sets complete flag, transmit request.
// - Complete flag is not set mid-transfer; an uncleared flag stays set.
// - Control register bit layout, reset 14h.
// - Rate code selects clock divide 2..128.
// - Select disable ignores select pin; in slave only with phase one.
// - Enable clear stops and resets engine.
// - Master bit selects master or slave.
// - Polarity sets idle level, phase edges.
// - Status register bit layout, reserved low.
// - Status read then data read clears complete.
// - Data write loads shifter, read gives buffer.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
module sif_spi_ctrl
    import sif_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              clockEn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    input  wire logic              sckIn,
    output logic                   sckOut,
    output logic                   sckOen,
    input  wire logic              mosiIn,
    output logic                   mosiOut,
    output logic                   mosiOen,
    input  wire logic              misoIn,
    output logic                   misoOut,
    output logic                   misoOen,
    input  wire logic              ssnIn,
    output logic                   txReq,
    output logic                   rxErrReq,
    output logic                   irqReq
);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter check.
    generate
        if (ADDR_W < ADDR_MIN) begin : gAddrCheck
            $error("ADDR_W too small for the register map.");
        end else if (ADDR_W > 32) begin : gAddrWide
            $error("ADDR_W wider than the bus address.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.
    function automatic sif_sel_t regSel(input logic [ADDR_W-1:0] addr);
        sif_sel_t sel;
        sel = SEL_NONE;
        if (addr == ADDR_W'({IDX_CTRL, 2'b00})) begin
            sel = SEL_CTRL;
        end else if (addr == ADDR_W'({IDX_STAT, 2'b00})) begin
            sel = SEL_STAT;
        end else if (addr == ADDR_W'({IDX_DATA, 2'b00})) begin
            sel = SEL_DATA;
        end
        return sel;
    endfunction

    // Enabled master role of a control value.
    function automatic logic masterOn(input logic [7:0] ctrl);
        return ctrl[CB_EN] & ctrl[CB_MASTER_SELECT];
    endfunction

    // Enabled slave role of a control value.
    function automatic logic slaveOn(input logic [7:0] ctrl);
        return ctrl[CB_EN] & ~ctrl[CB_MASTER_SELECT];
    endfunction

    // Slave select is ignored in slave mode only with select disable and phase one.
    function automatic logic ssIgnored(input logic [7:0] ctrl);
        return ctrl[CB_SELECT_DISABLE] & ctrl[CB_CLOCK_PHASE];
    endfunction

    // Last count of the half bit period for a rate code.
    function automatic logic [6:0] halfMax(input logic [2:0] rate);
        return 7'((7'h01 << rate) - 7'h01);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State.
    sif_state_t s;
    sif_state_t n;

    logic       acc;
    sif_sel_t   sel;
    logic       startReq;
    logic       spifSet;
    logic       wcolSet;
    logic       done;
    logic       en;
    logic       mst;
    logic       clock_polarity;
    logic       clock_phase;
    logic       select_disable;
    logic [2:0] rate;
    logic       ssSel;
    logic       ssFall;
    logic       ssRise;
    logic       sckLead;
    logic       sckTrail;
    logic       lead;
    logic       sample;

    always_comb begin
        n        = s;
        startReq = 1'b0;
        spifSet  = 1'b0;
        wcolSet  = 1'b0;
        done     = 1'b0;
        lead     = 1'b0;
        sample   = 1'b0;
        acc      = hsel & hready & (htrans == HT_NONSEQ);
        sel      = regSel(haddr);
        n.rdy    = 1'b1;
        n.resp   = HR_OKAY;

        ////////////////////////////////////////////////////////////////////////
        // Data phase of a write.
        if (s.wrPend) begin
            case (s.apSel)
                SEL_CTRL: begin
                    n.ctrl = hwdata[7:0];
                    if (s.modfArm) begin
                        n.mode_fault_flag = 1'b0;
                    end
                    n.modfArm = 1'b0;
                    if (!hwdata[CB_EN]) begin
                        n.slave_select_error_flag = 1'b0;
                    end
                end
                SEL_DATA: begin
                    if (s.phase == PH_XFER) begin
                        n.write_collision_flag  = 1'b1;
                        wcolSet = 1'b1;
                    end else begin
                        n.txSh   = hwdata[7:0];
                        startReq = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        en    = n.ctrl[CB_EN];
        mst   = n.ctrl[CB_MASTER_SELECT];
        clock_polarity  = n.ctrl[CB_CLOCK_POLARITY];
        clock_phase  = n.ctrl[CB_CLOCK_PHASE];
        select_disable = n.ctrl[CB_SELECT_DISABLE];
        rate  = {n.ctrl[CB_RATE2], n.ctrl[CB_RATE1], n.ctrl[CB_RATE0]};

        // select ignored in slave only with phase one
        ssSel    = ssIgnored(n.ctrl) | ~ssnIn;
        ssFall   = s.ssPrev & ~ssnIn;
        ssRise   = ~s.ssPrev & ssnIn;
        sckLead  = (sckIn != s.sckPrev) && (s.sckPrev == clock_polarity);
        sckTrail = (sckIn != s.sckPrev) && (s.sckPrev != clock_polarity);
        n.sckPrev = sckIn;
        n.ssPrev  = ssnIn;

        ////////////////////////////////////////////////////////////////////////
        // Shift engine.
        if (!en) begin
            n.phase  = PH_IDLE;
            n.bitCnt = 4'h0;
            n.divCnt = 7'h00;
            n.sckOut = clock_polarity;
        end else if (mst) begin
            if (s.phase == PH_IDLE) begin
                n.sckOut = clock_polarity;
                if (startReq && (rate != RATE_BAD)) begin
                    n.phase  = PH_XFER;
                    n.bitCnt = 4'h0;
                    n.divCnt = 7'h00;
                    if (!clock_phase) begin
                        n.outBit = n.txSh[7];
                        n.txSh   = {n.txSh[6:0], 1'b0};
                    end
                end
            end else if (s.divCnt == halfMax(rate)) begin
                n.divCnt = 7'h00;
                n.sckOut = ~s.sckOut;
                n.bitCnt = 4'(s.bitCnt + 4'h1);
                lead     = ~s.bitCnt[0];
                sample   = lead ^ clock_phase;
                if (sample) begin
                    n.rxSh = {s.rxSh[6:0], misoIn};
                end else begin
                    n.outBit = n.txSh[7];
                    n.txSh   = {n.txSh[6:0], 1'b0};
                end
                if (s.bitCnt == EDGE_LAST) begin
                    done    = 1'b1;
                    n.phase = PH_IDLE;
                end
            end else begin
                n.divCnt = 7'(s.divCnt + 7'h01);
            end
        end else begin
            n.sckOut = clock_polarity;
            if ((s.phase == PH_XFER) && !ssIgnored(n.ctrl) && ssRise) begin
                n.slave_select_error_flag  = 1'b1;
                n.phase  = PH_IDLE;
                n.bitCnt = 4'h0;
            end else if (!ssSel) begin
                n.phase  = PH_IDLE;
                n.bitCnt = 4'h0;
            end else if (s.phase == PH_IDLE) begin
                if ((!clock_phase && ssFall) || (clock_phase && sckLead)) begin
                    n.phase  = PH_XFER;
                    n.bitCnt = 4'h0;
                    n.outBit = n.txSh[7];
                    n.txSh   = {n.txSh[6:0], 1'b0};
                end
            end else begin
                if (clock_phase ? sckTrail : sckLead) begin
                    n.rxSh   = {s.rxSh[6:0], mosiIn};
                    n.bitCnt = 4'(s.bitCnt + 4'h1);
                    if (s.bitCnt == BIT_LAST) begin
                        done    = 1'b1;
                        n.phase = PH_IDLE;
                    end
                end else if (clock_phase ? sckLead : sckTrail) begin
                    n.outBit = n.txSh[7];
                    n.txSh   = {n.txSh[6:0], 1'b0};
                end
            end
        end

        if (done) begin
            if (!n.transfer_complete_flag) begin
                n.rxBuf = n.rxSh;
            end
            n.transfer_complete_flag  = 1'b1;
            spifSet = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////
        // Mode fault.
        if (masterOn(n.ctrl) && !select_disable && !ssnIn) begin
            n.mode_fault_flag = 1'b1;
            n.ctrl[CB_EN]   = 1'b0;
            n.ctrl[CB_MASTER_SELECT] = 1'b0;
            n.phase         = PH_IDLE;
            n.bitCnt        = 4'h0;
            n.sckOut        = clock_polarity;
        end

        ////////////////////////////////////////////////////////////////////////
        // Address phase: decode, read data and clearing sequences.
        n.wrPend = acc & hwrite;
        n.apSel  = acc ? sel : SEL_NONE;
        n.rdData = 8'h00;
        if (acc && !hwrite) begin
            case (sel)
                SEL_CTRL: n.rdData = n.ctrl;
                SEL_STAT: n.rdData = {n.transfer_complete_flag, n.write_collision_flag, n.slave_select_error_flag, n.mode_fault_flag, STAT_RSV};
                SEL_DATA: n.rdData = n.rxBuf;
                default:  n.rdData = 8'h00;
            endcase
        end
        if (acc && (sel == SEL_STAT)) begin
            n.wcolArm = 1'b1;
            if (!hwrite) begin
                n.spifArm = n.transfer_complete_flag;
                n.modfArm = n.mode_fault_flag;
            end
        end
        if (acc && (sel == SEL_DATA)) begin
            if (s.wcolArm && !wcolSet) begin
                n.write_collision_flag = 1'b0;
            end
            n.wcolArm = 1'b0;
            if (!hwrite) begin
                if (s.spifArm && !spifSet) begin
                    n.transfer_complete_flag = 1'b0;
                end
                n.spifArm = 1'b0;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Pin enables and requests.
        n.sckOen  = ~masterOn(n.ctrl);
        n.mosiOen = ~masterOn(n.ctrl);
        n.misoOen = ~(slaveOn(n.ctrl) & ssSel);
        n.txReq = n.transfer_complete_flag;
        // fault request gated by select disable
        n.rxReq = n.mode_fault_flag & ~n.ctrl[CB_SELECT_DISABLE];
        n.irq   = n.txReq | n.rxReq;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s         <= '0;
            s.ctrl    <= CTRL_RST;
            s.rdy     <= 1'b1;
            s.ssPrev  <= 1'b1;
            s.sckOen  <= 1'b1;
            s.mosiOen <= 1'b1;
            s.misoOen <= 1'b1;
        end else if (clockEn) begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign hreadyout = s.rdy;
    assign hrdata    = {24'h000000, s.rdData};
    assign hresp     = s.resp;
    assign sckOut    = s.sckOut;
    assign sckOen    = s.sckOen;
    assign mosiOut   = s.outBit;
    assign mosiOen   = s.mosiOen;
    assign misoOut   = s.outBit;
    assign misoOen   = s.misoOen;
    assign txReq     = s.txReq;
    assign rxErrReq  = s.rxReq;
    assign irqReq    = s.irq;

endmodule

// [verif/sif_spi_ctrl_sva.sv]
// Port checker of the serial interface control block and its bind.
`timescale 1ns/100ps
module sif_spi_ctrl_sva
    import sif_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              clock,
    input wire logic              rstn,
    input wire logic              clockEn,
    input wire logic              hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              sckOut,
    input wire logic              sckOen,
    input wire logic              mosiOen,
    input wire logic              misoOen,
    input wire logic              txReq,
    input wire logic              rxErrReq,
    input wire logic              irqReq
);
    localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'({IDX_CTRL, 2'h0});
    localparam logic [ADDR_W-1:0] A_DATA = ADDR_W'({IDX_DATA, 2'h0});
    logic take;
    logic ctrlWr;
    logic dataRd;
    assign take   = hsel && hready && clockEn && htrans == HT_NONSEQ;
    assign ctrlWr = take && hwrite && haddr == A_CTRL;
    assign dataRd = take && !hwrite && haddr == A_DATA;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////
    property p_irqMerge; irqReq == (txReq || rxErrReq); endproperty
    a_irqMerge: assert property (p_irqMerge) else $error("merged request wrong");
    property p_faultOff; $rose(rxErrReq) |-> sckOen && mosiOen; endproperty
    a_faultOff: assert property (p_faultOff) else $error("fault left master on");
    property p_faultClr; $fell(rxErrReq) |-> $past(ctrlWr, 2); endproperty
    a_faultClr: assert property (p_faultClr) else $error("fault cleared without write");
    property p_cplClr; $fell(txReq) |-> $past(dataRd); endproperty
    a_cplClr: assert property (p_cplClr) else $error("complete cleared without read");
    property p_cplEdge; $rose(txReq) && !sckOen |-> $changed(sckOut); endproperty
    a_cplEdge: assert property (p_cplEdge) else $error("complete off last edge");
    property p_sckRun; !sckOen && !$past(sckOen) && $changed(sckOut) && !txReq
        |-> ##[1:64] ($changed(sckOut) || sckOen); endproperty
    a_sckRun: assert property (p_sckRun) else $error("serial clock stalled");
    property p_oenPair; sckOen == mosiOen; endproperty
    a_oenPair: assert property (p_oenPair) else $error("master enables differ");
    property p_misoOff; !sckOen |-> misoOen; endproperty
    a_misoOff: assert property (p_misoOff) else $error("master drives slave line");
    property p_rdUpper; hrdata[31:8] == 24'h0; endproperty
    a_rdUpper: assert property (p_rdUpper) else $error("upper read bits set");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind sif_spi_ctrl sif_spi_ctrl_sva #(.ADDR_W(ADDR_W)) u_sva (
    .clock(clock), .rstn(rstn), .clockEn(clockEn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .sckOut(sckOut), .sckOen(sckOen),
    .mosiOen(mosiOen), .misoOen(misoOen), .txReq(txReq), .rxErrReq(rxErrReq), .irqReq(irqReq));

// [verif/sif_peer_model.sv]
// Behavioural far-side serial slave that exchanges one byte per frame.
`timescale 1ns/100ps
module sif_peer_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       ssn,
    input  wire logic       clock_polarity,
    input  wire logic       clock_phase,
    input  wire logic [7:0] txByte,
    output logic            miso,
    output logic [7:0]      rxByte
);
    logic [7:0] sh = 8'h00;
    logic       drv = 1'h0;
    logic       lead;
    initial rxByte = 8'h00;
    always @(negedge ssn) begin
        sh = txByte;
        drv = txByte[7];
    end
    always @(sck) begin
        lead = (sck != clock_polarity);
        if (!ssn && (lead != clock_phase)) begin
            rxByte = {rxByte[6:0], mosi};
            sh = {sh[6:0], 1'h0};
        end else if (!ssn) begin
            drv = sh[7];
        end
    end
    // A released line shows the inverse of the last bit.
    assign miso = ssn ? ~drv : drv;
endmodule

// [verif/sif_spi_ctrl_tb_top.sv]
// Self-checking bench of the serial interface control block.
`timescale 1ns/100ps
module sif_spi_ctrl_tb_top
    import sif_pkg::*;
;
    localparam int AW = 12;
    logic          clock = 1'h0, rstn = 1'h0, hwrite = 1'h0, ssnIn = 1'h1, tbSck = 1'h0;
    logic          peerSsn = 1'h1, rdDp = 1'h0, clkEn = 1'h1;
    logic [1:0]    htrans = 2'h0;
    logic [AW-1:0] haddr = 12'h000;
    logic [31:0]   hwdata = 32'h0, hrdata;
    logic [7:0]    ctl = CTRL_RST, peerTx = 8'h00, peerRx, d, p, expQ[$];
    logic          hreadyout, hresp, sckOut, sckOen, mosiOut, mosiOen, misoOut, misoOen;
    logic          txReq, rxErrReq, irqReq, peerMiso, sckPin, mosiPin, misoPin;
    int            errors = 0, comparisons = 0, seed = 45306, n;
    assign sckPin  = sckOen ? tbSck : sckOut;
    assign mosiPin = mosiOen ? tbSck : mosiOut;
    assign misoPin = misoOen ? peerMiso : misoOut;
    always #2 clock = ~clock;
    sif_spi_ctrl #(.ADDR_W(AW)) dut (
        .clock(clock), .rstn(rstn), .clockEn(clkEn), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .sckIn(sckPin), .sckOut(sckOut), .sckOen(sckOen), .mosiIn(mosiPin),
        .mosiOut(mosiOut), .mosiOen(mosiOen), .misoIn(misoPin), .misoOut(misoOut), .misoOen(misoOen),
        .ssnIn(ssnIn), .txReq(txReq), .rxErrReq(rxErrReq), .irqReq(irqReq));
    sif_peer_model peer (.sck(sckPin), .mosi(mosiPin), .ssn(peerSsn), .clock_polarity(ctl[CB_CLOCK_POLARITY]),
        .clock_phase(ctl[CB_CLOCK_PHASE]), .txByte(peerTx), .miso(peerMiso), .rxByte(peerRx));
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask
    task automatic cmp(input logic [31:0] a, input logic [31:0] e);
        comparisons++;
        if (a !== e) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, a, e);
        end
    endtask
    task automatic rdy;
        int k;
        k = 0;
        do begin
            tick(1);
            k++;
        end while (hreadyout !== 1'h1 && k < 50);
        if (hreadyout !== 1'h1) begin
            errors++;
            stop_test();
        end
    endtask
    task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] v);
        htrans <= HT_NONSEQ;
        hwrite <= wr;
        haddr  <= AW'({idx, 2'h0});
        rdy();
        htrans <= 2'h0;
        hwdata <= {24'h0, v};
        rdy();
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        expQ.push_back(e);
        acc(1'h0, idx, 8'h00);
    endtask
    task automatic start(input logic [7:0] v, input logic [7:0] q);
        peerTx <= q;
        tick(1);
        peerSsn <= 1'h0;
        acc(1'h1, IDX_DATA, v);
    endtask
    task automatic done;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (txReq !== 1'h1 && n < 2100);
        peerSsn <= 1'h1;
        if (n >= 2100) begin
            errors++;
            stop_test();
        end
    endtask
    // Read results are taken off the queue in their data phase.
    always @(posedge clock) begin
        if (rdDp) begin
            cmp(hrdata, {24'h0, expQ.pop_front()});
        end
        rdDp <= htrans == HT_NONSEQ && !hwrite && hreadyout;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(10);
        rstn <= 1'h1;
        tick(1);
        rd(IDX_CTRL, CTRL_RST);
        rd(IDX_STAT, 8'h00);
        acc(1'h1, 8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        $display("test reset done");
        for (int r = 0; r < 7; r++) begin
            ctl = {r[2], 3'h5, r[0], r[1], r[1:0]};
            acc(1'h1, IDX_CTRL, ctl & 8'hBF);
            acc(1'h1, IDX_CTRL, ctl);
            rd(IDX_CTRL, ctl);
            d = 8'($random(seed));
            p = 8'($random(seed));
            start(d, p);
            done();
            cmp(n, (16 << r) + 1);
            cmp(sckOut, ctl[CB_CLOCK_POLARITY]);
            cmp(peerRx, d);
            cmp(irqReq, 1'h1);
            rd(IDX_STAT, 8'h80);
            rd(IDX_DATA, p);
            rd(IDX_STAT, 8'h00);
        end
        $display("test rates done");
        ctl = 8'h50;
        acc(1'h1, IDX_CTRL, ctl);
        start(8'h3C, 8'hA5);
        done();
        start(8'hC3, 8'h5A);
        tick(20);
        peerSsn <= 1'h1;
        cmp(peerRx, 8'hC3);
        rd(IDX_STAT, 8'h80);
        rd(IDX_DATA, 8'hA5);
        rd(IDX_STAT, 8'h00);
        $display("test overrun done");
        ctl = 8'h53;
        acc(1'h1, IDX_CTRL, ctl);
        start(8'h96, 8'h69);
        tick(10);
        acc(1'h1, IDX_DATA, 8'h0F);
        cmp(irqReq, 1'h0);
        rd(IDX_STAT, 8'h40);
        done();
        cmp(peerRx, 8'h96);
        rd(IDX_STAT, 8'hC0);
        rd(IDX_DATA, 8'h69);
        rd(IDX_STAT, 8'h00);
        $display("test collision done");
        start(8'h11, 8'h22);
        tick(10);
        acc(1'h1, IDX_CTRL, 8'h13);
        peerSsn <= 1'h1;
        tick(300);
        cmp(txReq, 1'h0);
        cmp(sckOen, 1'h1);
        $display("test disable done");
        acc(1'h1, IDX_CTRL, 8'h54);
        ssnIn <= 1'h0;
        tick(4);
        cmp(rxErrReq, 1'h1);
        cmp(sckOen, 1'h1);
        rd(IDX_CTRL, 8'h04);
        acc(1'h1, IDX_CTRL, 8'h24);
        tick(1);
        cmp(rxErrReq, 1'h0);
        rd(IDX_STAT, 8'h10);
        ssnIn <= 1'h1;
        acc(1'h1, IDX_CTRL, 8'h04);
        rd(IDX_STAT, 8'h00);
        acc(1'h1, IDX_CTRL, 8'h74);
        ssnIn <= 1'h0;
        tick(4);
        rd(IDX_STAT, 8'h00);
        cmp(sckOen, 1'h0);
        ssnIn <= 1'h1;
        $display("test fault done");
        acc(1'h1, IDX_CTRL, 8'h44);
        ssnIn <= 1'h0;
        tick(3);
        cmp(misoOen, 1'h0);
        tbSck <= 1'h1;
        tick(3);
        tbSck <= 1'h0;
        tick(3);
        ssnIn <= 1'h1;
        tick(3);
        rd(IDX_STAT, 8'h20);
        cmp(irqReq, 1'h0);
        acc(1'h1, IDX_CTRL, 8'h04);
        rd(IDX_STAT, 8'h00);
        $display("test slave done");
        clkEn <= 1'h0;
        acc(1'h1, IDX_CTRL, 8'h54);
        clkEn <= 1'h1;
        rd(IDX_CTRL, 8'h04);
        $display("test freeze done");
        tick(2);
        stop_test();
    end
endmodule
